// File: rtl/pidc_pkg.sv
package pidc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_GAIN   = 8'h04;
  localparam logic [7:0]  OFF_ITIME  = 8'h08;
  localparam logic [7:0]  OFF_DTIME  = 8'h0c;
  localparam logic [7:0]  OFF_FTIME  = 8'h10;
  localparam logic [7:0]  OFF_CMD    = 8'h14;
  localparam logic [7:0]  OFF_FBK    = 8'h18;
  localparam logic [7:0]  OFF_DEV    = 8'h1c;
  localparam logic [7:0]  OFF_MV     = 8'h20;
  localparam int          CTRL_EN    = 0;
  localparam int          CTRL_BIP   = 1;

  // ****************************************************************
  // reset values and setting limits
  // ****************************************************************
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [15:0] GAIN_RST   = 16'h03e8;
  localparam logic [15:0] TIME_RST   = 16'h0000;
  localparam logic [15:0] GAIN_MAX   = 16'h7530;
  localparam logic [15:0] ITIME_MAX  = 16'h8ca0;
  localparam logic [15:0] DTIME_MAX  = 16'hea60;
  localparam logic [15:0] FTIME_MAX  = 16'h2328;
  localparam logic [15:0] PCT_FULL   = 16'h4000;
  localparam logic [31:0] GAIN_DEN   = 32'h0000_03e8;
  localparam logic [31:0] TENTH_MS   = 32'h0000_0064;
  localparam logic [31:0] HUND_MS    = 32'h0000_000a;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_FREQ_KHZ   = 200000;
  localparam int          SAMPLE_TIME_MS = 1;
  localparam int          SAMPLE_CYCLES  = SAMPLE_TIME_MS * CLK_FREQ_KHZ;
  localparam logic [31:0] SAMPLE_MS      = 32'(SAMPLE_TIME_MS);
  localparam int          DIV_STEPS      = 48;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_FILT, ST_DEV, ST_PROP, ST_INT, ST_DLAUNCH, ST_DER, ST_SUM
  } pidc_state_t;

  typedef struct packed {
    pidc_state_t        st;
    logic [31:0]        tick_cnt;
    logic [1:0]         ctrl;
    logic [15:0]        kp;
    logic [15:0]        ti;
    logic [15:0]        td;
    logic [15:0]        tf;
    logic signed [15:0] cmd;
    logic [15:0]        fb_m;
    logic [15:0]        fb_s;
    logic signed [31:0] fb_acc;
    logic signed [17:0] dev;
    logic signed [23:0] prop;
    logic signed [23:0] prop_prev;
    logic signed [39:0] integ;
    logic signed [23:0] deriv;
    logic signed [15:0] mv;
    logic               div_go;
    logic               div_neg;
    logic [47:0]        div_num;
    logic [31:0]        div_den;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } pidc_core_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [32:0] rem;
    logic [47:0] quot;
  } pidc_div_st_t;

endpackage : pidc_pkg

// File: rtl/pidc_divider.sv
`timescale 1ns/1ps
`default_nettype none

module pidc_divider (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // request
  input  wire logic        i_start,
  input  wire logic [47:0] i_num,
  input  wire logic [31:0] i_den,
  // answer
  output logic             o_done,
  output logic [47:0]      o_quot
);

  // ****************************************************************
  // restoring divider, one quotient bit per clock
  // ****************************************************************
  // den must stay stable while busy; the caller holds it in a register
  pidc_pkg::pidc_div_st_t s;
  pidc_pkg::pidc_div_st_t next_s;

  always_comb begin
    logic [32:0] sh;
    sh = {s.rem[31:0], s.quot[47]};
    next_s = s;
    next_s.done = 1'b0;
    if (!s.busy) begin
      if (i_start) begin
        next_s.busy = 1'b1;
        next_s.cnt  = 6'h00;
        next_s.rem  = 33'h0;
        next_s.quot = i_num;
      end
    end else begin
      next_s.quot = {s.quot[46:0], 1'b0};
      if (sh >= {1'b0, i_den}) begin
        next_s.rem     = sh - {1'b0, i_den};
        next_s.quot[0] = 1'b1;
      end else begin
        next_s.rem = sh;
      end
      next_s.cnt = s.cnt + 6'h01;
      if (s.cnt == 6'(pidc_pkg::DIV_STEPS - 1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_done = s.done;
  assign o_quot = s.quot;

endmodule : pidc_divider

`default_nettype wire

// File: rtl/pidc_controller.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RL1: gain 0 to 30 times scales deviation
// RL2: proportional term follows present deviation linearly
// RL3: integral time 0 to 3600 s
// RL4: zero integral time clears integral term
// RL5: integral accumulates deviation each sample
// RL6: derivative time 0 to 600 s
// RL7: zero derivative time removes derivative term
// RL8: derivative follows deviation change times time
// RL9: output sums proportional, integral, derivative terms
// RL10: feedback filter time 0 to 900 s
// RL11: first-order low-pass on feedback before deviation
// RL12: bipolar feedback spans minus to plus full
// RL13: unipolar feedback spans zero to full
// RL14: operator sets dancer reference near midpoint
// RL15: operator uses input filters for fine filtering
// RL16: deviation is command minus filtered feedback
// RL17: output and integral saturate, never wrap
module pidc_controller #(
  parameter int SAMPLE_CYCLES = pidc_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // feedback sensor, q14 percent, asynchronous
  input  wire logic [15:0] i_feedback,
  // frequency reference
  output logic [15:0]      o_manipulated_value
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] clamp16(input logic [31:0] x, input logic [15:0] lim);
    clamp16 = (x > {16'h0, lim}) ? lim : x[15:0];
  endfunction : clamp16

  function automatic logic signed [47:0] sat48(input logic signed [47:0] x,
                                               input logic signed [47:0] lim);
    if (x > lim) begin
      sat48 = lim;
    end else if (x < -lim) begin
      sat48 = -lim;
    end else begin
      sat48 = x;
    end
  endfunction : sat48

  function automatic logic [47:0] mag48(input logic signed [47:0] x);
    mag48 = x[47] ? 48'(-x) : 48'(x);
  endfunction : mag48

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= pidc_pkg::OFF_MV);
  endfunction : mapped

  // ****************************************************************
  // state and shared signals
  // ****************************************************************
  localparam logic signed [47:0] LIM16  = 48'sh0000_0000_7fff;
  localparam logic signed [47:0] LIM24  = 48'sh0000_007f_ffff;
  localparam logic signed [47:0] LIMINT = 48'sh0000_7fff_0000;

  pidc_pkg::pidc_core_t s;
  pidc_pkg::pidc_core_t next_s;

  logic               div_done;
  logic [47:0]        div_quot;
  logic signed [47:0] div_q;
  logic signed [15:0] fb_in;
  logic               tick;
  logic               xfer;
  logic signed [47:0] mv_sum;

  assign div_q  = s.div_neg ? -$signed(div_quot) : $signed(div_quot);
  assign tick   = (s.tick_cnt == 32'(SAMPLE_CYCLES - 1));
  assign xfer   = i_psel && i_penable && s.pready;
  assign mv_sum = 48'(s.prop) + 48'(s.integ >>> 16) + 48'(s.deriv);

  // sensor range limits: a unipolar sensor never reads below zero
  always_comb begin
    logic signed [15:0] raw;
    raw = $signed(s.fb_s);
    if (raw > $signed(pidc_pkg::PCT_FULL)) begin
      fb_in = $signed(pidc_pkg::PCT_FULL);                         // [RL12] [RL13]
    end else if (s.ctrl[pidc_pkg::CTRL_BIP] && raw < -$signed(pidc_pkg::PCT_FULL)) begin
      fb_in = -$signed(pidc_pkg::PCT_FULL);                        // [RL12]
    end else if (!s.ctrl[pidc_pkg::CTRL_BIP] && raw[15]) begin
      fb_in = 16'sh0000;                                           // [RL13]
    end else begin
      fb_in = raw;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic signed [47:0] diff;
    logic signed [47:0] pnew;
    logic signed [17:0] dnew;
    diff   = 48'sh0;
    pnew   = 48'sh0;
    dnew   = 18'sh0;
    next_s = s;
    next_s.div_go = 1'b0;
    next_s.fb_m   = i_feedback;
    next_s.fb_s   = s.fb_m;
    next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;

    // apb: answer prepared in setup, access completes with no wait
    if (i_psel && !i_penable) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped(i_paddr);
      case (i_paddr)
        pidc_pkg::OFF_CTRL:  next_s.prdata = {30'h0, s.ctrl};
        pidc_pkg::OFF_GAIN:  next_s.prdata = {16'h0, s.kp};
        pidc_pkg::OFF_ITIME: next_s.prdata = {16'h0, s.ti};
        pidc_pkg::OFF_DTIME: next_s.prdata = {16'h0, s.td};
        pidc_pkg::OFF_FTIME: next_s.prdata = {16'h0, s.tf};
        pidc_pkg::OFF_CMD:   next_s.prdata = 32'(s.cmd);
        pidc_pkg::OFF_FBK:   next_s.prdata = 32'(s.fb_acc >>> 16);
        pidc_pkg::OFF_DEV:   next_s.prdata = 32'(s.dev);
        pidc_pkg::OFF_MV:    next_s.prdata = 32'(s.mv);
        default:             next_s.prdata = 32'h0;
      endcase
    end else if (xfer) begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (i_pwrite) begin
        case (i_paddr)
          pidc_pkg::OFF_CTRL:  next_s.ctrl = i_pwdata[1:0];
          pidc_pkg::OFF_GAIN:  next_s.kp = clamp16(i_pwdata, pidc_pkg::GAIN_MAX);   // [RL1]
          pidc_pkg::OFF_ITIME: next_s.ti = clamp16(i_pwdata, pidc_pkg::ITIME_MAX);  // [RL3]
          pidc_pkg::OFF_DTIME: next_s.td = clamp16(i_pwdata, pidc_pkg::DTIME_MAX);  // [RL6]
          pidc_pkg::OFF_FTIME: next_s.tf = clamp16(i_pwdata, pidc_pkg::FTIME_MAX);  // [RL10]
          pidc_pkg::OFF_CMD:   next_s.cmd = $signed(i_pwdata[15:0]);
          default:             next_s.ctrl = s.ctrl;
        endcase
      end
    end

    // ****************************************************************
    // one pass per sample; each division takes the shared divider
    // ****************************************************************
    case (s.st)
      pidc_pkg::ST_IDLE: begin
        if (tick && s.ctrl[pidc_pkg::CTRL_EN]) begin
          if (s.tf == 16'h0) begin
            next_s.fb_acc = {fb_in, 16'h0};                       // [RL11]
            next_s.st     = pidc_pkg::ST_DEV;
          end else begin
            // y += (x - y) * ts / tf, kept with 16 fraction bits
            // widen as signed so a negative bipolar reading keeps its sign
            diff = 48'($signed({fb_in, 16'h0})) - 48'(s.fb_acc);  // [RL11]
            next_s.div_go  = 1'b1;
            next_s.div_neg = diff[47];
            next_s.div_num = 48'(mag48(diff) * pidc_pkg::SAMPLE_MS);
            next_s.div_den = 32'(s.tf) * pidc_pkg::TENTH_MS;      // [RL10]
            next_s.st      = pidc_pkg::ST_FILT;
          end
        end
      end
      pidc_pkg::ST_FILT: begin
        if (div_done) begin
          next_s.fb_acc = s.fb_acc + 32'(div_q);                  // [RL11]
          next_s.st     = pidc_pkg::ST_DEV;
        end
      end
      pidc_pkg::ST_DEV: begin
        dnew = 18'(s.cmd) - 18'(s.fb_acc >>> 16);                 // [RL16]
        next_s.dev     = dnew;
        next_s.div_go  = 1'b1;
        next_s.div_neg = dnew[17];
        next_s.div_num = mag48(48'(dnew)) * 48'(s.kp);            // [RL1] [RL2]
        next_s.div_den = pidc_pkg::GAIN_DEN;
        next_s.st      = pidc_pkg::ST_PROP;
      end
      pidc_pkg::ST_PROP: begin
        if (div_done) begin
          pnew = sat48(div_q, LIM24);                             // [RL2]
          next_s.prop      = 24'(pnew);
          next_s.prop_prev = s.prop;
          if (s.ti != 16'h0) begin
            // integral step = kp * e * ts / ti
            next_s.div_go  = 1'b1;
            next_s.div_neg = pnew[47];
            next_s.div_num = 48'({mag48(pnew), 16'h0} * pidc_pkg::SAMPLE_MS);   // [RL5]
            next_s.div_den = 32'(s.ti) * pidc_pkg::TENTH_MS;      // [RL3]
            next_s.st      = pidc_pkg::ST_INT;
          end else begin
            next_s.st = pidc_pkg::ST_DLAUNCH;
          end
        end
      end
      pidc_pkg::ST_INT: begin
        if (div_done) begin
          next_s.integ = 40'(sat48(48'(s.integ) + div_q, LIMINT)); // [RL5] [RL17]
          next_s.st    = pidc_pkg::ST_DLAUNCH;
        end
      end
      pidc_pkg::ST_DLAUNCH: begin
        if (s.td != 16'h0) begin
          // derivative = kp * de * td / ts
          diff = 48'(s.prop) - 48'(s.prop_prev);                  // [RL8]
          next_s.div_go  = 1'b1;
          next_s.div_neg = diff[47];
          next_s.div_num = 48'(mag48(diff) * 48'(s.td) * 48'(pidc_pkg::HUND_MS)); // [RL6]
          next_s.div_den = pidc_pkg::SAMPLE_MS;
          next_s.st      = pidc_pkg::ST_DER;
        end else begin
          next_s.deriv = 24'sh0;                                  // [RL7]
          next_s.st    = pidc_pkg::ST_SUM;
        end
      end
      pidc_pkg::ST_DER: begin
        if (div_done) begin
          next_s.deriv = 24'(sat48(div_q, LIM24));                // [RL8] [RL17]
          next_s.st    = pidc_pkg::ST_SUM;
        end
      end
      pidc_pkg::ST_SUM: begin
        next_s.mv = 16'(sat48(mv_sum, LIM16));                    // [RL9] [RL17]
        next_s.st = pidc_pkg::ST_IDLE;
      end
      default: begin
        next_s.st = pidc_pkg::ST_IDLE;
      end
    endcase

    // integral time of zero holds the integrator empty
    if (s.ti == 16'h0) begin
      next_s.integ = 40'sh0;                                      // [RL4]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s      <= '0;
      s.st   <= pidc_pkg::ST_IDLE;
      s.ctrl <= pidc_pkg::CTRL_RST;
      s.kp   <= pidc_pkg::GAIN_RST;
      s.ti   <= pidc_pkg::TIME_RST;
      s.td   <= pidc_pkg::TIME_RST;
      s.tf   <= pidc_pkg::TIME_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // divider, shared by filter, gain, integral and derivative
  // ****************************************************************
  pidc_divider u_div (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (s.div_go),
    .i_num     (s.div_num),
    .i_den     (s.div_den),
    .o_done    (div_done),
    .o_quot    (div_quot)
  );

  assign o_prdata            = s.prdata;
  assign o_pready            = s.pready;
  assign o_pslverr           = s.pslverr;
  assign o_manipulated_value = s.mv;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_launch;
    s.st == pidc_pkg::ST_IDLE && tick && s.ctrl[pidc_pkg::CTRL_EN];
  endsequence

  sequence s_gain_big;
    xfer && i_pwrite && i_paddr == pidc_pkg::OFF_GAIN && i_pwdata > {16'h0, pidc_pkg::GAIN_MAX};
  endsequence

  sequence s_prop_done;
    s.st == pidc_pkg::ST_PROP && div_done;
  endsequence

  sample_pass_a: assert property (s_launch |-> ##[1:400] s.st == pidc_pkg::ST_SUM) // [RL16]
    else $error("sample pass did not finish");
  filt_bypass_a: assert property (s_launch ##0 s.tf == 16'h0 |=> // [RL11]
                                  s.fb_acc == {$past(fb_in), 16'h0})
    else $error("unfiltered feedback not taken");
  unipolar_clip_a: assert property (s_launch ##0 !s.ctrl[1] ##0 s.tf == 16'h0 |=> // [RL13]
                                    !s.fb_acc[31])
    else $error("unipolar feedback went negative");
  dev_calc_a: assert property (s.st == pidc_pkg::ST_DEV |=> // [RL16]
                               s.dev == 18'($past(s.cmd)) - 18'($past(s.fb_acc) >>> 16))
    else $error("deviation wrong");
  int_off_a: assert property (s.ti == 16'h0 |=> s.integ == 40'sh0) // [RL4]
    else $error("integral active with zero time");
  der_off_a: assert property (s.st == pidc_pkg::ST_DLAUNCH && s.td == 16'h0 |=> // [RL7]
                              s.deriv == 24'sh0 && s.st == pidc_pkg::ST_SUM)
    else $error("derivative active with zero time");
  prop_sign_a: assert property (s.st == pidc_pkg::ST_PROP && div_done && s.kp != 16'h0 |=> // [RL2]
                                s.prop == 24'sh0 || s.prop[23] == s.dev[17])
    else $error("proportional sign differs from deviation");
  mv_sat_a: assert property (s.st == pidc_pkg::ST_SUM && mv_sum > LIM16 |=> // [RL17]
                             s.mv == 16'sh7fff && s.st == pidc_pkg::ST_IDLE)
    else $error("output not saturated");
  gain_clamp_a: assert property (s_gain_big |=> s.kp == pidc_pkg::GAIN_MAX) // [RL1]
    else $error("gain not limited");
  mv_hold_a: assert property (s.st != pidc_pkg::ST_SUM |=> $stable(s.mv)) // [RL9]
    else $error("output changed outside the sum step");
  idle_hold_a: assert property (s.st == pidc_pkg::ST_IDLE && // [RL16]
                                !s.ctrl[pidc_pkg::CTRL_EN] |=> s.st == pidc_pkg::ST_IDLE)
    else $error("pass started while disabled");
  int_range_a: assert property (48'(s.integ) <= LIMINT && 48'(s.integ) >= -LIMINT) // [RL17]
    else $error("integrator beyond its limit");
  time_range_a: assert property (s.ti <= pidc_pkg::ITIME_MAX && // [RL3] [RL6] [RL10]
                                 s.td <= pidc_pkg::DTIME_MAX && s.tf <= pidc_pkg::FTIME_MAX)
    else $error("time setting beyond its limit");
  int_skip_a: assert property (s_prop_done ##0 s.ti == 16'h0 |=> // [RL4]
                               s.st == pidc_pkg::ST_DLAUNCH)
    else $error("integral step taken with zero time");
  int_step_a: assert property (s_prop_done ##0 s.ti != 16'h0 |=> // [RL5]
                               s.st == pidc_pkg::ST_INT && s.div_go)
    else $error("integral step not launched");

endmodule : pidc_controller

`default_nettype wire

// File: testbench/pidc_sensor.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// feedback sensor model
// ****************************************************************
module pidc_sensor (
  // clock
  input  wire logic        i_ref_clk,
  // level the bench asks for, q14 percent
  input  wire logic [15:0] i_level,
  // sensor output
  output logic [15:0]      o_feedback
);
  // the sensor settles one clock after it is asked; fine smoothing is left to
  // the analog input side, so the level passes here untouched
  always_ff @(posedge i_ref_clk) begin
    o_feedback <= i_level;
  end
endmodule : pidc_sensor

`default_nettype wire

// File: testbench/pidc_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pidc_controller_tb;
  // ****************************************************************
  // clock, bus and notes
  // ****************************************************************
  // short sample period keeps the run small; math still assumes 1 ms
  localparam int SC = 300;
  localparam logic [31:0] CT [4] = '{32'h1, 32'h1, 32'h3, 32'h3};
  localparam logic [15:0] LV [4] = '{16'hfc18, 16'h4e20, 16'hb1e0, 16'hfc18};
  localparam logic [31:0] EF [4] = '{32'h0, 32'h4000, 32'hffffc000, 32'hfffffc18};
  typedef struct packed {logic chk; logic err; logic [31:0] dat;} pidc_note_t;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [15:0] lvl     = 16'h0;
  logic [31:0] lfsr    = 32'hc040367e;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] fbk;
  logic [15:0] mv;
  pidc_note_t  notes [$];
  pidc_note_t  cur;
  int          err_total = 0;
  int          compares  = 0;

  always #2.5 clk = ~clk;

  pidc_sensor i_sensor (.i_ref_clk(clk), .i_level(lvl), .o_feedback(fbk));

  pidc_controller #(.SAMPLE_CYCLES(SC)) i_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_feedback(fbk),
    .o_manipulated_value(mv)
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  task automatic fail(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask : cmp

  // one idle cycle before each setup, so no signal is assigned twice at one edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input pidc_note_t n, output logic [31:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    if (!wr) notes.push_back(n);
    // pready and read data are taken at the rising edge; a hang ends by the watchdog
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, '0, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, '{1'b1, er, e}, q);
  endtask : rd

  task automatic rdq(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, '0, q);
  endtask : rdq

  task automatic tk(input int n);
    repeat (n * SC) @(posedge clk);
  endtask : tk

  task automatic mvw(input logic [15:0] e);
    logic [15:0] o;
    int k;
    k = 0;
    @(negedge clk);
    o = mv;
    while (mv === o && k < 4 * SC) begin
      k++;
      @(negedge clk);
    end
    cmp({16'h0, mv}, {16'h0, e}, "output step");
  endtask : mvw

  task automatic test_done;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // read results are judged here, against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.chk) begin
        compares++;
        if (prdata !== cur.dat || pslverr !== cur.err) fail("read data");
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail("watchdog");
    test_done();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [31:0] q, c, g, e, g1, g2;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'(4 * i), (i == 1) ? 32'h3e8 : 32'h0);
    rd(8'h24, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    wr(pidc_pkg::OFF_MV, 32'h1234);
    rd(pidc_pkg::OFF_MV, 32'h0);
    wr(pidc_pkg::OFF_GAIN, 32'h9c40);
    rd(pidc_pkg::OFF_GAIN, 32'h7530);
    wr(pidc_pkg::OFF_ITIME, 32'hc350);
    rd(pidc_pkg::OFF_ITIME, 32'h8ca0);
    wr(pidc_pkg::OFF_DTIME, 32'h11170);
    rd(pidc_pkg::OFF_DTIME, 32'hea60);
    wr(pidc_pkg::OFF_FTIME, 32'h2710);
    rd(pidc_pkg::OFF_FTIME, 32'h2328);
    wr(pidc_pkg::OFF_ITIME, 32'h0);
    wr(pidc_pkg::OFF_DTIME, 32'h0);
    wr(pidc_pkg::OFF_FTIME, 32'h0);
    wr(pidc_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      lfsr = rnd(lfsr);
      c = lfsr % 32'h4000;
      lfsr = rnd(lfsr);
      g = lfsr % 32'h7531;
      wr(pidc_pkg::OFF_GAIN, g);
      wr(pidc_pkg::OFF_CMD, c);
      tk(2);
      e = c * g / 32'h3e8;
      if (e > 32'h7fff) e = 32'h7fff;
      rd(pidc_pkg::OFF_DEV, c);
      rd(pidc_pkg::OFF_MV, e);
      cmp({16'h0, mv}, e, "proportional");
    end
    wr(pidc_pkg::OFF_GAIN, 32'h3e8);
    wr(pidc_pkg::OFF_CMD, 32'h2000);
    for (int i = 0; i < 4; i++) begin
      wr(pidc_pkg::OFF_CTRL, CT[i]);
      lvl <= LV[i];
      tk(2);
      rd(pidc_pkg::OFF_FBK, EF[i]);
      rd(pidc_pkg::OFF_DEV, 32'h2000 - EF[i]);
    end
    wr(pidc_pkg::OFF_GAIN, 32'h7530);
    wr(pidc_pkg::OFF_CMD, 32'h4000);
    lvl <= 16'hc000;
    tk(2);
    rd(pidc_pkg::OFF_MV, 32'h7fff);
    wr(pidc_pkg::OFF_CMD, 32'hffffc000);
    lvl <= 16'h4000;
    tk(2);
    rd(pidc_pkg::OFF_MV, 32'hffff8001);
    cmp({16'h0, mv}, 32'h8001, "negative limit");
    wr(pidc_pkg::OFF_CTRL, 32'h1);
    lvl <= 16'h0;
    wr(pidc_pkg::OFF_GAIN, 32'h3e8);
    wr(pidc_pkg::OFF_CMD, 32'h1000);
    wr(pidc_pkg::OFF_ITIME, 32'ha);
    tk(20);
    rdq(pidc_pkg::OFF_MV, g1);
    wr(pidc_pkg::OFF_ITIME, 32'h0);
    tk(2);
    rd(pidc_pkg::OFF_MV, 32'h1000);
    wr(pidc_pkg::OFF_ITIME, 32'h64);
    tk(20);
    rdq(pidc_pkg::OFF_MV, g2);
    compares++;
    // ten times the integral time must give some growth, but less than a fifth of it
    if ((g2 > 32'h1000) !== 1'b1 || (g1 - 32'h1000 > 5 * (g2 - 32'h1000)) !== 1'b1) begin
      fail("integral rate");
    end
    wr(pidc_pkg::OFF_ITIME, 32'h0);
    wr(pidc_pkg::OFF_CMD, 32'h0);
    tk(2);
    wr(pidc_pkg::OFF_CMD, 32'h64);
    mvw(16'h64);
    wr(pidc_pkg::OFF_CMD, 32'h0);
    mvw(16'h0);
    wr(pidc_pkg::OFF_DTIME, 32'h1);
    tk(2);
    wr(pidc_pkg::OFF_CMD, 32'h64);
    mvw(16'h44c);
    mvw(16'h64);
    wr(pidc_pkg::OFF_DTIME, 32'h0);
    wr(pidc_pkg::OFF_CMD, 32'h0);
    tk(2);
    wr(pidc_pkg::OFF_FTIME, 32'ha);
    lvl <= 16'h4000;
    tk(5);
    rdq(pidc_pkg::OFF_FBK, q);
    compares++;
    if ((q > 32'h0 && q < 32'h666) !== 1'b1) fail("filter speed");
    wr(pidc_pkg::OFF_FTIME, 32'h0);
    tk(2);
    rd(pidc_pkg::OFF_FBK, 32'h4000);
    cmp({16'h0, mv}, 32'hc000, "filtered output");
    wr(pidc_pkg::OFF_CTRL, 32'h0);
    wr(pidc_pkg::OFF_CMD, 32'h1000);
    tk(3);
    cmp({16'h0, mv}, 32'hc000, "disabled hold");
    rd(pidc_pkg::OFF_MV, 32'hffffc000);
    test_done();
  end
endmodule : pidc_controller_tb

`default_nettype wire
